// [rmxo_unit.sv]
/*
 * rmxo_unit: executes register moves, bank reads, stack loads, swaps and the
 * sleep instruction, holds the programmer registers and the condition codes.
 * Assumes opcodes arrive from a fetch stage on the same clock, and that the
 * interrupt logic pulses irq_accept on the same clock.
 */
// Overview of operation
// - p1/p3 pair moves, two cycles, flags kept
// - p2 to p1, p3 to p2, flags kept
// - p2 pair into p3 pair, flags kept
// - p2 bank into B low, high zeroed
// - p3 bank into B low, high zeroed
// - stack gets p2 pair minus two
// - stack gets p3 pair minus two
// - swap D and pointer two
// - swap D and pointer three
// - swap E and pointer one
// - swap E and pointer two
// - swap E and pointer three
// - result update writes flag bits, bank kept
// - branch count picks taken or not taken
// - pull-all replaces whole condition code word
// - pull-bank replaces only program bank
`timescale 1ns/10ps

module rmxo_unit
    import rmxo_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic op_valid,
    input wire logic [15:0] op_code,
    output logic op_ready,
    output logic op_done,
    output logic op_illegal,
    output logic sleeping,
    input wire logic irq_accept,
    input wire rmxo_load_t reg_load,
    input wire rmxo_cc_upd_t cc_upd,
    input wire rmxo_branch_t branch_counts,
    input wire logic branch_taken,
    output logic [7:0] branch_cycles,
    output rmxo_regs_t regs,
    output logic [15:0] cond_code_reg
);

    typedef enum logic [2:0] {
        RMXO_IDLE = 3'b001,
        RMXO_EXEC = 3'b010,
        RMXO_SLEEP = 3'b100
    } rmxo_state_t;

    // cycle count of an opcode; zero marks one this unit does not handle
    function automatic logic [3:0] op_cycles(input logic [15:0] op);
        logic [3:0] n;
        n = CYC_NONE;
        case (op)
            OP_MOVE_P1_TO_P3, OP_MOVE_P3_TO_P1, OP_MOVE_P2_TO_P1,
            OP_MOVE_P3_TO_P2, OP_MOVE_P2_TO_P3, OP_READ_P2_BANK,
            OP_READ_P3_BANK, OP_LOAD_STACK_FROM_P2, OP_LOAD_STACK_FROM_P3,
            OP_SWAP_A_B, OP_SWAP_D_E, OP_SWAP_D_P1, OP_SWAP_D_P2,
            OP_SWAP_D_P3, OP_SWAP_E_P1, OP_SWAP_E_P2, OP_SWAP_E_P3: begin
                n = CYC_MOVE;
            end
            OP_SLEEP_UNTIL_IRQ: begin
                n = CYC_SLEEP;
            end
            default: begin
                n = CYC_NONE;
            end
        endcase
        return n;
    endfunction

    // register effect of an opcode; none of them reaches the flags
    function automatic rmxo_regs_t op_apply(input logic [15:0] op, input rmxo_regs_t r);
        rmxo_regs_t n;
        logic [19:0] sum;
        n = r;
        sum = 20'h00000;
        case (op)
            OP_MOVE_P1_TO_P3: begin
                n.pointer_three_bank = r.pointer_one_bank;
                n.pointer_three = r.pointer_one;
            end
            OP_MOVE_P3_TO_P1: begin
                n.pointer_one_bank = r.pointer_three_bank;
                n.pointer_one = r.pointer_three;
            end
            OP_MOVE_P2_TO_P1: begin
                n.pointer_one_bank = r.pointer_two_bank;
                n.pointer_one = r.pointer_two;
            end
            OP_MOVE_P3_TO_P2: begin
                n.pointer_two_bank = r.pointer_three_bank;
                n.pointer_two = r.pointer_three;
            end
            OP_MOVE_P2_TO_P3: begin
                n.pointer_three_bank = r.pointer_two_bank;
                n.pointer_three = r.pointer_two;
            end
            OP_READ_P2_BANK: begin
                n.acc_b = {4'h0, r.pointer_two_bank};
            end
            OP_READ_P3_BANK: begin
                n.acc_b = {4'h0, r.pointer_three_bank};
            end
            OP_LOAD_STACK_FROM_P2: begin
                // the borrow runs into the bank, so a wrap below zero moves the bank
                sum = {r.pointer_two_bank, r.pointer_two} - STACK_ADJUST;
                {n.stack_bank, n.stack_top} = sum;
            end
            OP_LOAD_STACK_FROM_P3: begin
                sum = {r.pointer_three_bank, r.pointer_three} - STACK_ADJUST;
                {n.stack_bank, n.stack_top} = sum;
            end
            OP_SWAP_D_P2: begin
                {n.acc_a, n.acc_b} = r.pointer_two;
                n.pointer_two = {r.acc_a, r.acc_b};
            end
            OP_SWAP_D_P3: begin
                {n.acc_a, n.acc_b} = r.pointer_three;
                n.pointer_three = {r.acc_a, r.acc_b};
            end
            OP_SWAP_E_P1: begin
                n.acc_e = r.pointer_one;
                n.pointer_one = r.acc_e;
            end
            OP_SWAP_E_P2: begin
                n.acc_e = r.pointer_two;
                n.pointer_two = r.acc_e;
            end
            OP_SWAP_E_P3: begin
                n.acc_e = r.pointer_three;
                n.pointer_three = r.acc_e;
            end
            OP_SWAP_A_B: begin
                n.acc_a = r.acc_b;
                n.acc_b = r.acc_a;
            end
            OP_SWAP_D_E: begin
                {n.acc_a, n.acc_b} = r.acc_e;
                n.acc_e = {r.acc_a, r.acc_b};
            end
            OP_SWAP_D_P1: begin
                {n.acc_a, n.acc_b} = r.pointer_one;
                n.pointer_one = {r.acc_a, r.acc_b};
            end
            default: begin
                n = r;
            end
        endcase
        return n;
    endfunction

    rmxo_state_t state;
    logic [15:0] cur_op;
    logic [3:0] cyc_left;
    logic [3:0] new_cycles;
    logic accept;
    logic last_cycle;

    assign new_cycles = op_cycles(op_code);
    assign op_ready = (state == RMXO_IDLE);
    assign accept = op_valid && op_ready;
    assign last_cycle = (state == RMXO_EXEC) && (cyc_left == 4'h1);
    assign sleeping = (state == RMXO_SLEEP);

    // sequencer: every instruction spends its full count before it retires
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state <= RMXO_IDLE;
            cur_op <= RESET_WORD;
            cyc_left <= 4'h0;
        end else begin
            case (state)
                RMXO_IDLE: begin
                    // an opcode not handled here keeps the unit idle; op_illegal reports it
                    if (accept && new_cycles != CYC_NONE) begin
                        cur_op <= op_code;
                        // the take cycle is the first of the count, so one less is left
                        cyc_left <= new_cycles - 4'h1;
                        state <= RMXO_EXEC;
                    end
                end
                RMXO_EXEC: begin
                    if (cyc_left == 4'h1) begin
                        // sleep holds the unit until an interrupt is taken
                        state <= (cur_op == OP_SLEEP_UNTIL_IRQ) ? RMXO_SLEEP : RMXO_IDLE;
                    end
                    // reaches zero on the exit edge and is reloaded by the next take
                    cyc_left <= cyc_left - 4'h1;
                end
                RMXO_SLEEP: begin
                    if (irq_accept) begin
                        state <= RMXO_IDLE;
                    end
                end
                default: begin
                    state <= RMXO_IDLE;
                end
            endcase
        end
    end

    // retire and refuse pulses
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            op_done <= 1'b0;
            op_illegal <= 1'b0;
        end else begin
            // a sleep retires on its wake edge, not at the end of its count
            op_done <= (last_cycle && cur_op != OP_SLEEP_UNTIL_IRQ)
                || (sleeping && irq_accept);
            op_illegal <= accept && (new_cycles == CYC_NONE);
        end
    end

    // programmer registers: the preload port only acts while idle
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            regs <= '0;
        end else if (last_cycle) begin
            regs <= op_apply(cur_op, regs);
        end else if (op_ready && reg_load.valid) begin
            // byte and bank targets take only the low bits of the data word
            case (reg_load.sel)
                RMXO_SEL_A: begin
                    regs.acc_a <= reg_load.data[7:0];
                end
                RMXO_SEL_B: begin
                    regs.acc_b <= reg_load.data[7:0];
                end
                RMXO_SEL_E: begin
                    regs.acc_e <= reg_load.data;
                end
                RMXO_SEL_P1: begin
                    regs.pointer_one <= reg_load.data;
                end
                RMXO_SEL_P2: begin
                    regs.pointer_two <= reg_load.data;
                end
                RMXO_SEL_P3: begin
                    regs.pointer_three <= reg_load.data;
                end
                RMXO_SEL_STACK: begin
                    regs.stack_top <= reg_load.data;
                end
                RMXO_SEL_K1: begin
                    regs.pointer_one_bank <= reg_load.data[3:0];
                end
                RMXO_SEL_K2: begin
                    regs.pointer_two_bank <= reg_load.data[3:0];
                end
                RMXO_SEL_K3: begin
                    regs.pointer_three_bank <= reg_load.data[3:0];
                end
                RMXO_SEL_STACK_BANK: begin
                    regs.stack_bank <= reg_load.data[3:0];
                end
                default: begin
                    // a load to an unknown selector is dropped
                    regs <= regs;
                end
            endcase
        end
    end

    // condition codes: only the rest of the core writes them, never this unit's ops
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cond_code_reg <= RESET_WORD;
        end else begin
            // an update in the middle of an instruction is safe: no op here writes flags
            case (cc_upd.kind)
                RMXO_CC_RESULT: begin
                    cond_code_reg[15:CC_FLAG_LSB] <= cc_upd.value[15:CC_FLAG_LSB];
                end
                RMXO_CC_PULL_ALL: begin
                    cond_code_reg <= cc_upd.value;
                end
                RMXO_CC_PULL_BANK: begin
                    cond_code_reg[CC_BANK_MSB:0] <= cc_upd.value[CC_BANK_MSB:0];
                end
                default: begin
                    cond_code_reg <= cond_code_reg;
                end
            endcase
        end
    end

    // branch timing: the taken figure is the first of the pair
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            branch_cycles <= 8'h00;
        end else begin
            // registered so the fetch stage sees the count from a flop
            branch_cycles <= branch_taken ? branch_counts.taken_cycles
                : branch_counts.not_taken_cycles;
        end
    end

endmodule

// [rmxo_pkg.sv]
/*
 * rmxo_pkg: constants and types for the register move / exchange unit.
 * Assumes a single core clock and a synchronous active-high reset.
 */
package rmxo_pkg;
    // opcodes of the no-operand instructions handled here
    localparam logic [15:0] OP_MOVE_P1_TO_P3 = 16'h276c;
    localparam logic [15:0] OP_MOVE_P3_TO_P1 = 16'h274e;
    localparam logic [15:0] OP_MOVE_P2_TO_P1 = 16'h274d;
    localparam logic [15:0] OP_MOVE_P3_TO_P2 = 16'h275e;
    localparam logic [15:0] OP_MOVE_P2_TO_P3 = 16'h276d;
    localparam logic [15:0] OP_READ_P2_BANK = 16'h37ad;
    localparam logic [15:0] OP_READ_P3_BANK = 16'h37ae;
    localparam logic [15:0] OP_LOAD_STACK_FROM_P2 = 16'h375e;
    localparam logic [15:0] OP_LOAD_STACK_FROM_P3 = 16'h376e;
    localparam logic [15:0] OP_SLEEP_UNTIL_IRQ = 16'h27f3;
    localparam logic [15:0] OP_SWAP_A_B = 16'h371a;
    localparam logic [15:0] OP_SWAP_D_E = 16'h277a;
    localparam logic [15:0] OP_SWAP_D_P1 = 16'h37cc;
    localparam logic [15:0] OP_SWAP_D_P2 = 16'h37dc;
    localparam logic [15:0] OP_SWAP_D_P3 = 16'h37ec;
    localparam logic [15:0] OP_SWAP_E_P1 = 16'h374c;
    localparam logic [15:0] OP_SWAP_E_P2 = 16'h375c;
    localparam logic [15:0] OP_SWAP_E_P3 = 16'h376c;

    // cycle counts
    localparam logic [3:0] CYC_MOVE = 4'h2;
    localparam logic [3:0] CYC_SLEEP = 4'h8;
    localparam logic [3:0] CYC_NONE = 4'h0;

    // stack adjustment and field positions
    localparam logic [19:0] STACK_ADJUST = 20'h00002;
    localparam int CC_BANK_MSB = 3;
    localparam int CC_FLAG_LSB = 4;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [3:0] RESET_BANK = 4'h0;

    // selector of the preload port
    typedef enum logic [3:0] {
        RMXO_SEL_A = 4'h0, RMXO_SEL_B = 4'h1, RMXO_SEL_E = 4'h2,
        RMXO_SEL_P1 = 4'h3, RMXO_SEL_P2 = 4'h4, RMXO_SEL_P3 = 4'h5,
        RMXO_SEL_STACK = 4'h6, RMXO_SEL_K1 = 4'h7, RMXO_SEL_K2 = 4'h8,
        RMXO_SEL_K3 = 4'h9, RMXO_SEL_STACK_BANK = 4'ha
    } rmxo_sel_t;

    // kind of condition code update from the rest of the core
    typedef enum logic [1:0] {
        RMXO_CC_NONE = 2'h0,
        RMXO_CC_RESULT = 2'h1,
        RMXO_CC_PULL_ALL = 2'h2,
        RMXO_CC_PULL_BANK = 2'h3
    } rmxo_cc_kind_t;

    typedef struct packed {
        logic [7:0] acc_a;
        logic [7:0] acc_b;
        logic [15:0] acc_e;
        logic [15:0] pointer_one;
        logic [15:0] pointer_two;
        logic [15:0] pointer_three;
        logic [15:0] stack_top;
        logic [3:0] pointer_one_bank;
        logic [3:0] pointer_two_bank;
        logic [3:0] pointer_three_bank;
        logic [3:0] stack_bank;
    } rmxo_regs_t;

    typedef struct packed {
        logic valid;
        rmxo_sel_t sel;
        logic [15:0] data;
    } rmxo_load_t;

    typedef struct packed {
        rmxo_cc_kind_t kind;
        logic [15:0] value;
    } rmxo_cc_upd_t;

    typedef struct packed {
        logic [7:0] taken_cycles;
        logic [7:0] not_taken_cycles;
    } rmxo_branch_t;
endpackage

// [rmxo_unit_properties.sv]
/*
 * rmxo_unit_checker: concurrent checks on the ports of rmxo_unit.
 * Assumes one core clock and a synchronous active-high reset.
 */
`timescale 1ns/10ps

module rmxo_unit_checker
    import rmxo_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic op_valid,
    input wire logic [15:0] op_code,
    input wire logic op_ready,
    input wire logic op_done,
    input wire logic sleeping,
    input wire logic irq_accept,
    input wire rmxo_cc_upd_t cc_upd,
    input wire rmxo_branch_t branch_counts,
    input wire logic branch_taken,
    input wire logic [7:0] branch_cycles,
    input wire rmxo_regs_t regs,
    input wire logic [15:0] cond_code_reg
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    // opcode accepted at this edge
    sequence s_take(logic [15:0] c);
        op_valid && op_ready && op_code == c;
    endsequence

    // one busy cycle, then retired with ready back
    sequence s_retire2;
        !op_ready ##1 (op_ready && op_done);
    endsequence

    a_move_two_cycle: assert property (s_take(OP_MOVE_P1_TO_P3) |=> s_retire2)
        else $error("pair move did not retire after two cycles");
    a_move_p2_p3: assert property (s_take(OP_MOVE_P2_TO_P3) |-> ##2
        regs.pointer_three == $past(regs.pointer_two, 2)
        && regs.pointer_three_bank == $past(regs.pointer_two_bank, 2))
        else $error("second pair not copied into third pair");
    a_bank_read: assert property (s_take(OP_READ_P2_BANK) |-> ##2
        regs.acc_b == {4'h0, $past(regs.pointer_two_bank, 2)})
        else $error("bank read into B wrong");
    a_stack_adjust: assert property (s_take(OP_LOAD_STACK_FROM_P3) |-> ##2
        {regs.stack_bank, regs.stack_top} == {$past(regs.pointer_three_bank, 2),
        $past(regs.pointer_three, 2)} - STACK_ADJUST)
        else $error("stack load is not pointer minus two");
    a_swap_e_p1: assert property (s_take(OP_SWAP_E_P1) |-> ##2
        regs.acc_e == $past(regs.pointer_one, 2) && regs.pointer_one == $past(regs.acc_e, 2))
        else $error("E and pointer one not exchanged");
    a_flags_kept: assert property (cc_upd.kind == RMXO_CC_NONE |=> $stable(cond_code_reg))
        else $error("condition codes changed without an update");
    a_cc_result: assert property (cc_upd.kind == RMXO_CC_RESULT |=>
        cond_code_reg == {$past(cc_upd.value[15:4]), $past(cond_code_reg[3:0])})
        else $error("result update wrong");
    a_cc_pull_bank: assert property (cc_upd.kind == RMXO_CC_PULL_BANK |=>
        cond_code_reg == {$past(cond_code_reg[15:4]), $past(cc_upd.value[3:0])})
        else $error("bank pull touched other bits");
    a_branch_pick: assert property (1'b1 |=> branch_cycles == ($past(branch_taken) ?
        $past(branch_counts.taken_cycles) : $past(branch_counts.not_taken_cycles)))
        else $error("branch count pick wrong");
    a_sleep_entry: assert property (s_take(OP_SLEEP_UNTIL_IRQ) |=>
        (!sleeping && !op_ready) [*7] ##1 sleeping)
        else $error("sleep not entered after eight cycles");
    a_irq_wake: assert property (sleeping && irq_accept |=> !sleeping && op_done)
        else $error("interrupt did not end sleep");
endmodule

bind rmxo_unit rmxo_unit_checker u_rmxo_unit_checker (.clock(clock), .sys_rst(sys_rst),
    .op_valid(op_valid), .op_code(op_code), .op_ready(op_ready), .op_done(op_done),
    .sleeping(sleeping), .irq_accept(irq_accept), .cc_upd(cc_upd),
    .branch_counts(branch_counts), .branch_taken(branch_taken),
    .branch_cycles(branch_cycles), .regs(regs), .cond_code_reg(cond_code_reg));

// [tb_register_move_exchange_ops.sv]
/*
 * tb_register_move_exchange_ops: directed scenarios for rmxo_unit.
 * Assumes the checker is bound in from its own file; one core clock.
 */
`timescale 1ns/10ps

module tb_register_move_exchange_ops;
    import rmxo_pkg::*;

    logic clock, sys_rst, op_valid, irq_accept, branch_taken;
    logic op_ready, op_done, op_illegal, sleeping;
    logic [15:0] op_code, cond_code_reg, e, p1, p2, p3;
    logic [7:0] branch_cycles, a, b;
    rmxo_load_t reg_load;
    rmxo_cc_upd_t cc_upd;
    rmxo_branch_t branch_counts;
    rmxo_regs_t regs;
    int n_errors = 0;
    int check_count = 0;
    int n;
    logic [15:0] swap_ops [8] = '{OP_SWAP_A_B, OP_SWAP_D_E, OP_SWAP_D_P1, OP_SWAP_D_P2,
        OP_SWAP_D_P3, OP_SWAP_E_P1, OP_SWAP_E_P2, OP_SWAP_E_P3};

    rmxo_unit u_rmxo_unit (.clock(clock), .sys_rst(sys_rst), .op_valid(op_valid),
        .op_code(op_code), .op_ready(op_ready), .op_done(op_done), .op_illegal(op_illegal),
        .sleeping(sleeping), .irq_accept(irq_accept), .reg_load(reg_load),
        .cc_upd(cc_upd), .branch_counts(branch_counts), .branch_taken(branch_taken),
        .branch_cycles(branch_cycles), .regs(regs), .cond_code_reg(cond_code_reg));

    // 4 ns period
    always #2 clock = ~clock;

    // inputs move 1 ns after the edge so sampling never races
    task automatic tick;
        @(posedge clock);
        #1;
    endtask

    task automatic check(input logic [79:0] got, input logic [79:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // extra idle cycle first, so a preload never lands on a retire cycle
    task automatic preload(input rmxo_sel_t sel, input logic [15:0] data);
        tick;
        reg_load = '{1'b1, sel, data};
        tick;
        reg_load.valid = 1'b0;
    endtask

    // n counts cycles from the take, itself the first, to retire or sleep; 20 caps a hang
    task automatic run_op(input logic [15:0] code);
        op_valid = 1'b1;
        op_code = code;
        tick;
        op_valid = 1'b0;
        n = 1;
        do begin
            tick;
            n++;
        end while (op_done !== 1'b1 && sleeping !== 1'b1 && n < 20);
    endtask

    function automatic logic [59:0] ptrs();
        return {regs.pointer_one_bank, regs.pointer_one, regs.pointer_two_bank,
            regs.pointer_two, regs.pointer_three_bank, regs.pointer_three};
    endfunction

    task automatic t_moves;
        preload(RMXO_SEL_P1, 16'h1234);
        preload(RMXO_SEL_K1, 16'h0005);
        preload(RMXO_SEL_P2, 16'habcd);
        preload(RMXO_SEL_K2, 16'h0006);
        run_op(OP_MOVE_P1_TO_P3);
        check(n, 2);
        check(ptrs(), 60'h512346abcd51234);
        run_op(OP_MOVE_P2_TO_P1);
        check(ptrs(), 60'h6abcd6abcd51234);
        run_op(OP_MOVE_P3_TO_P1);
        check(ptrs(), 60'h512346abcd51234);
        run_op(OP_MOVE_P3_TO_P2);
        check(ptrs(), 60'h512345123451234);
        preload(RMXO_SEL_P2, 16'h5555);
        preload(RMXO_SEL_K2, 16'h0009);
        run_op(OP_MOVE_P2_TO_P3);
        check(ptrs(), 60'h512349555595555);
    endtask

    // bank reads clear the high nibble; stack load borrows into the bank
    task automatic t_banks;
        preload(RMXO_SEL_B, 16'h00ff);
        run_op(OP_READ_P2_BANK);
        check({regs.acc_a, regs.acc_b}, 16'h0009);
        preload(RMXO_SEL_K3, 16'h00fc);
        run_op(OP_READ_P3_BANK);
        check({regs.acc_a, regs.acc_b}, 16'h000c);
        run_op(OP_LOAD_STACK_FROM_P2);
        check({regs.stack_bank, regs.stack_top}, 20'h95553);
        preload(RMXO_SEL_P3, 16'h0001);
        run_op(OP_LOAD_STACK_FROM_P3);
        check({regs.stack_bank, regs.stack_top}, 20'hbffff);
    endtask

    task automatic t_swaps;
        {a, b, e, p1, p2, p3} = 80'h1234_5678_1111_2222_3333;
        preload(RMXO_SEL_A, 16'h0012);
        preload(RMXO_SEL_B, 16'h0034);
        preload(RMXO_SEL_E, 16'h5678);
        preload(RMXO_SEL_P1, 16'h1111);
        preload(RMXO_SEL_P2, 16'h2222);
        preload(RMXO_SEL_P3, 16'h3333);
        foreach (swap_ops[i]) begin
            run_op(swap_ops[i]);
            case (swap_ops[i])
                OP_SWAP_A_B: {a, b} = {b, a};
                OP_SWAP_D_E: {a, b, e} = {e, a, b};
                OP_SWAP_D_P1: {a, b, p1} = {p1, a, b};
                OP_SWAP_D_P2: {a, b, p2} = {p2, a, b};
                OP_SWAP_D_P3: {a, b, p3} = {p3, a, b};
                OP_SWAP_E_P1: {e, p1} = {p1, e};
                OP_SWAP_E_P2: {e, p2} = {p2, e};
                default: {e, p3} = {p3, e};
            endcase
            check({regs.acc_a, regs.acc_b, regs.acc_e, regs.pointer_one, regs.pointer_two,
                regs.pointer_three}, {a, b, e, p1, p2, p3});
        end
    endtask

    task automatic t_sleep;
        run_op(OP_SLEEP_UNTIL_IRQ);
        check(n, 8);
        repeat (4) tick;
        check({sleeping, op_ready}, 2'b10);
        irq_accept = 1'b1;
        tick;
        irq_accept = 1'b0;
        check({sleeping, op_done}, 2'b01);
    endtask

    task automatic t_flags;
        cc_upd = '{RMXO_CC_PULL_ALL, 16'hbeef};
        tick;
        check(cond_code_reg, 16'hbeef);
        cc_upd = '{RMXO_CC_RESULT, 16'h1230};
        tick;
        check(cond_code_reg, 16'h123f);
        cc_upd = '{RMXO_CC_PULL_BANK, 16'hfff5};
        tick;
        check(cond_code_reg, 16'h1235);
        cc_upd = '{RMXO_CC_NONE, 16'hffff};
        run_op(OP_SWAP_D_E);
        check(cond_code_reg, 16'h1235);
        branch_counts = '{8'h0a, 8'h06};
        branch_taken = 1'b1;
        tick;
        check(branch_cycles, 8'h0a);
        branch_taken = 1'b0;
        tick;
        check(branch_cycles, 8'h06);
    endtask

    // an opcode outside this unit is refused at once and leaves B alone
    task automatic t_refuse;
        preload(RMXO_SEL_B, 16'h00a5);
        op_valid = 1'b1;
        op_code = 16'h37af;
        tick;
        op_valid = 1'b0;
        check({op_illegal, op_ready, op_done}, 3'b110);
        tick;
        check({op_illegal, regs.acc_b}, 9'h0a5);
    endtask

    task automatic final_report;
        if (n_errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // whole run is about ninety cycles; this cuts a hang short
    initial begin
        #8000;
        n_errors++;
        final_report;
    end

    initial begin
        clock = 1'b0;
        sys_rst = 1'b1;
        {op_valid, irq_accept, branch_taken, op_code} = '0;
        {reg_load, cc_upd, branch_counts} = '0;
        repeat (3) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        t_moves;
        t_banks;
        t_swaps;
        t_sleep;
        t_flags;
        t_refuse;
        final_report;
    end
endmodule
